// ==== fcs_defines.svh ====
// register offsets, field positions, opcodes and reset values of the flash command front end
// assumes a word-aligned bus slave that decodes the low address byte
//
// Summary of operation
// - a command runs only when its key field equals the pass value
// - opcodes 1 to 4 are page write, write-lock, erase-write, erase-write-lock
// - plane erase takes a page number inside the plane to erase
// - sector erase takes any page number inside that sector
// - multi-page erase size from argument bits 1:0: 4, 8, 16 or 32 pages
// - opcodes 8, 9, 10 set, clear, query a region lock; argument names page
// - opcodes 11, 12, 13 set, clear, query a nv bit; argument names bit
// - opcode 14 starts and 15 stops reading the identifier area
// - opcodes 18, 19 write and erase signature; 20, 21 start and stop reading
// - status bit 0 is ready; it drops when an operation starts
// - interrupt request while ready and mode bit 0 are both set
// - status bit 1 flags bad opcode or key; status read or command write clears
// - status bit 2 flags locked-region hit; status read or command write clears
// - status bit 3 flags verify failure; clears when next programming begins
// - corrected ecc errors set bits 16 low half and 18 high; status read clears
// - uncorrected ecc errors set bits 17 low and 19 high; held until status read
// - query results come word by word on successive result register reads
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

`define FCS_OFF_MODE 8'h00
`define FCS_OFF_CMD 8'h04
`define FCS_OFF_STATUS 8'h08
`define FCS_OFF_RESULT 8'h0C

`define FCS_KEY_HI 31
`define FCS_KEY_LO 24
`define FCS_ARG_HI 23
`define FCS_ARG_LO 8
`define FCS_OP_HI 7
`define FCS_OP_LO 0
`define FCS_KEY_PASS 8'h5A

`define FCS_OP_GET_DESC 8'h00
`define FCS_OP_WRITE_PAGE 8'h01
`define FCS_OP_WRITE_LOCK 8'h02
`define FCS_OP_ERASE_WRITE 8'h03
`define FCS_OP_ERASE_WRITE_LOCK 8'h04
`define FCS_OP_ERASE_ALL 8'h05
`define FCS_OP_ERASE_PLANE 8'h06
`define FCS_OP_ERASE_PAGES 8'h07
`define FCS_OP_SET_LOCK 8'h08
`define FCS_OP_CLEAR_LOCK 8'h09
`define FCS_OP_GET_LOCK 8'h0A
`define FCS_OP_SET_NV 8'h0B
`define FCS_OP_CLEAR_NV 8'h0C
`define FCS_OP_GET_NV 8'h0D
`define FCS_OP_START_ID 8'h0E
`define FCS_OP_STOP_ID 8'h0F
`define FCS_OP_GET_CALIB 8'h10
`define FCS_OP_ERASE_SECTOR 8'h11
`define FCS_OP_WRITE_SIG 8'h12
`define FCS_OP_ERASE_SIG 8'h13
`define FCS_OP_START_SIG 8'h14
`define FCS_OP_STOP_SIG 8'h15

`define FCS_ST_READY 0
`define FCS_ST_CMD_ERR 1
`define FCS_ST_LOCK_ERR 2
`define FCS_ST_VERIFY_ERR 3
`define FCS_ST_ECC_LO 16
`define FCS_ST_ECC_HI 19

`define FCS_MODE_RESET 32'h0400_0000
`define FCS_MODE_MASK 32'h0501_0F01
`define FCS_MODE_IRQ_EN 0
`define FCS_MODE_WS_HI 11
`define FCS_MODE_WS_LO 8
`define FCS_MODE_SEQ_DIS 16
`define FCS_MODE_ACC64 24
`define FCS_MODE_LOOP_EN 26

`endif

// ==== fcs_pkg.sv ====
// types shared by the flash command front end
// assumes nothing beyond the defines header
package fcs_pkg;
    typedef enum logic {FCS_IDLE, FCS_BUSY} fcs_state_t;

    typedef struct packed {
        logic valid;
        logic prog;
        logic query;
        logic id_on;
        logic id_off;
        logic sig_on;
        logic sig_off;
        logic [15:0] page;
        logic [5:0] count;
    } fcs_dec_t;
endpackage

// ==== fcs_reg_if.sv ====
// register strobes between the bus slave and the register file
// assumes one clock for both ends
`timescale 1ns/1ps
`default_nettype none
interface fcs_reg_if;
    logic wr;
    logic [7:0] wr_addr;
    logic [31:0] wdata;
    logic rd;
    logic [7:0] rd_addr;
    logic [31:0] rdata;
    modport bus (output wr, wr_addr, wdata, rd, rd_addr, input rdata);
    modport regs (input wr, wr_addr, wdata, rd, rd_addr, output rdata);
endinterface
`default_nettype wire

// ==== fcs_ahb_slave.sv ====
// zero-wait AHB-Lite slave turning transfers into register strobes
// assumes single word transfers; read data muxed by the register file
`timescale 1ns/1ps
`default_nettype none
module fcs_ahb_slave
    import fcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    fcs_reg_if.bus rif
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } fcs_slv_state_t;

    fcs_slv_state_t s_r;
    fcs_slv_state_t s_nxt;
    logic acc;

    // frozen clock enable stalls the master
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign acc = hsel & htrans[1] & hready & ce;
    assign rif.rd = acc & ~hwrite;
    assign rif.rd_addr = haddr[7:0];
    assign rif.wr = s_r.wr_pend & ce;
    assign rif.wr_addr = s_r.wr_addr;
    assign rif.wdata = hwdata;

    always_comb begin
        s_nxt = s_r;
        if (hready) begin
            s_nxt.wr_pend = acc & hwrite;
        end
        if (acc) begin
            s_nxt.wr_addr = haddr[7:0];
        end
        if (rif.rd) begin
            s_nxt.rdata = rif.rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
endmodule // fcs_ahb_slave
`default_nettype wire

// ==== fcs_cmd_decode.sv ====
// opcode decode of a command word into operation class and target pages
// assumes key checking is done by the caller
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_cmd_decode
    import fcs_pkg::*;
(
    input wire logic [31:0] word,
    output fcs_dec_t dec
);
    logic [7:0] op;
    logic [15:0] arg;
    logic [15:0] mask;

    assign op = word[`FCS_OP_HI:`FCS_OP_LO];
    assign arg = word[`FCS_ARG_HI:`FCS_ARG_LO];

    always_comb begin
        dec = '0;
        mask = 16'hFFFF;
        dec.page = arg;
        dec.count = 6'h01;
        dec.valid = (op <= `FCS_OP_STOP_SIG);
        unique case (op)
            `FCS_OP_WRITE_PAGE, `FCS_OP_WRITE_LOCK, `FCS_OP_ERASE_WRITE,
            `FCS_OP_ERASE_WRITE_LOCK: begin
                dec.prog = 1'b1;
            end
            `FCS_OP_ERASE_ALL, `FCS_OP_ERASE_PLANE, `FCS_OP_ERASE_SECTOR: begin
                dec.prog = 1'b1;
            end
            `FCS_OP_ERASE_PAGES: begin
                dec.prog = 1'b1;
                dec.count = 6'(6'h04 << arg[1:0]);
                mask = ~(16'(dec.count) - 16'h0001);
                dec.page = {arg[15:2], 2'b00} & mask;
            end
            `FCS_OP_WRITE_SIG, `FCS_OP_ERASE_SIG: begin
                dec.prog = 1'b1;
            end
            `FCS_OP_GET_DESC, `FCS_OP_GET_LOCK, `FCS_OP_GET_NV, `FCS_OP_GET_CALIB: begin
                dec.query = 1'b1;
            end
            `FCS_OP_START_ID: begin
                dec.id_on = 1'b1;
            end
            `FCS_OP_STOP_ID: begin
                dec.id_off = 1'b1;
            end
            `FCS_OP_START_SIG: begin
                dec.sig_on = 1'b1;
            end
            `FCS_OP_STOP_SIG: begin
                dec.sig_off = 1'b1;
            end
            default: begin
                dec.prog = 1'b0;
            end
        endcase
    end
endmodule // fcs_cmd_decode
`default_nettype wire

// ==== fcs_top.sv ====
// flash command front end: mode, command, status and result registers, op sequencer
// assumes a flash back end on the same clock that pulses done and ecc events
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_top
    import fcs_pkg::*;
#(
    parameter int RES_DEPTH = 8
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic FLASH_START,
    output logic [7:0] FLASH_OPCODE,
    output logic [15:0] FLASH_ARG,
    output logic [15:0] FLASH_PAGE,
    output logic [5:0] FLASH_PAGE_COUNT,
    input wire logic FLASH_DONE,
    input wire logic FLASH_VERIFY_FAIL,
    input wire logic FLASH_LOCK_HIT,
    input wire logic RESULT_PUSH,
    input wire logic [31:0] RESULT_WORD,
    input wire logic ECC_SINGLE_LO,
    input wire logic ECC_MULTI_LO,
    input wire logic ECC_SINGLE_HI,
    input wire logic ECC_MULTI_HI,
    output logic ID_AREA_SEL,
    output logic SIG_AREA_SEL,
    output logic [3:0] FLASH_WAIT_STATES,
    output logic SEQ_OPT_DISABLE,
    output logic ACCESS_64BIT,
    output logic LOOP_OPT_EN,
    output logic READY_IRQ
);
    localparam int CW = $clog2(RES_DEPTH + 1);

    typedef struct packed {
        fcs_state_t st;
        logic [31:0] mode;
        logic cmd_err;
        logic lock_err;
        logic ver_err;
        logic [3:0] ecc;
        logic start;
        logic [7:0] op;
        logic [15:0] arg;
        logic [15:0] page;
        logic [5:0] count;
        logic prog;
        logic id_sel;
        logic sig_sel;
        logic [RES_DEPTH-1:0][31:0] res;
        logic [CW-1:0] res_cnt;
        logic [CW-1:0] res_ptr;
    } fcs_top_state_t;

    fcs_top_state_t s_r;
    fcs_top_state_t s_nxt;
    fcs_reg_if rif ();
    fcs_dec_t dec;
    logic ready;
    logic cmd_wr;
    logic key_ok;
    logic accept;
    logic stat_rd;
    logic res_rd;
    logic [31:0] stat_word;
    logic [31:0] res_word;

    fcs_ahb_slave u_slave (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .hrdata(HRDATA),
        .hreadyout(HREADYOUT),
        .hresp(HRESP),
        .rif(rif.bus)
    );

    fcs_cmd_decode u_dec (
        .word(rif.wdata),
        .dec(dec)
    );

    assign ready = (s_r.st == FCS_IDLE);
    assign cmd_wr = rif.wr && (rif.wr_addr == `FCS_OFF_CMD);
    assign key_ok = (rif.wdata[`FCS_KEY_HI:`FCS_KEY_LO] == `FCS_KEY_PASS);
    assign accept = cmd_wr && key_ok && dec.valid && ready;
    assign stat_rd = rif.rd && (rif.rd_addr == `FCS_OFF_STATUS);
    assign res_rd = rif.rd && (rif.rd_addr == `FCS_OFF_RESULT);

    always_comb begin
        stat_word = '0;
        stat_word[`FCS_ST_READY] = ready;
        stat_word[`FCS_ST_CMD_ERR] = s_r.cmd_err;
        stat_word[`FCS_ST_LOCK_ERR] = s_r.lock_err;
        stat_word[`FCS_ST_VERIFY_ERR] = s_r.ver_err;
        stat_word[`FCS_ST_ECC_HI:`FCS_ST_ECC_LO] = s_r.ecc;
        res_word = '0;
        if (s_r.res_ptr < s_r.res_cnt) begin
            res_word = s_r.res[s_r.res_ptr];
        end
    end

    always_comb begin
        rif.rdata = '0;
        unique case (rif.rd_addr)
            `FCS_OFF_MODE: begin
                rif.rdata = s_r.mode;
            end
            `FCS_OFF_STATUS: begin
                rif.rdata = stat_word;
            end
            `FCS_OFF_RESULT: begin
                rif.rdata = res_word;
            end
            default: begin
                rif.rdata = '0;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        if (rif.wr && (rif.wr_addr == `FCS_OFF_MODE)) begin
            s_nxt.mode = rif.wdata & `FCS_MODE_MASK;
        end
        // clears first so that a same-cycle event still sets
        if (stat_rd) begin
            s_nxt.cmd_err = 1'b0;
            s_nxt.lock_err = 1'b0;
            s_nxt.ecc = 4'h0;
        end
        if (cmd_wr) begin
            s_nxt.cmd_err = 1'b0;
            s_nxt.lock_err = 1'b0;
            if (!accept) begin
                s_nxt.cmd_err = 1'b1;
            end
        end
        if (accept) begin
            s_nxt.st = FCS_BUSY;
            s_nxt.start = 1'b1;
            s_nxt.op = rif.wdata[`FCS_OP_HI:`FCS_OP_LO];
            s_nxt.arg = rif.wdata[`FCS_ARG_HI:`FCS_ARG_LO];
            s_nxt.page = dec.page;
            s_nxt.count = dec.count;
            s_nxt.prog = dec.prog;
            if (dec.prog) begin
                s_nxt.ver_err = 1'b0;
            end
            if (dec.query) begin
                s_nxt.res_cnt = '0;
                s_nxt.res_ptr = '0;
            end
            if (dec.id_on) begin
                s_nxt.id_sel = 1'b1;
            end
            if (dec.id_off) begin
                s_nxt.id_sel = 1'b0;
            end
            if (dec.sig_on) begin
                s_nxt.sig_sel = 1'b1;
            end
            if (dec.sig_off) begin
                s_nxt.sig_sel = 1'b0;
            end
        end
        if ((s_r.st == FCS_BUSY) && FLASH_DONE) begin
            s_nxt.st = FCS_IDLE;
            if (s_r.prog && FLASH_VERIFY_FAIL) begin
                s_nxt.ver_err = 1'b1;
            end
            if (s_r.prog && FLASH_LOCK_HIT) begin
                s_nxt.lock_err = 1'b1;
            end
        end
        s_nxt.ecc = s_nxt.ecc | {ECC_MULTI_HI, ECC_SINGLE_HI,
                                 ECC_MULTI_LO, ECC_SINGLE_LO};
        if (res_rd && (s_r.res_ptr < s_r.res_cnt)) begin
            s_nxt.res_ptr = CW'(s_r.res_ptr + 1'b1);
        end
        if (RESULT_PUSH && (s_r.res_cnt < CW'(RES_DEPTH))) begin
            s_nxt.res[s_r.res_cnt] = RESULT_WORD;
            s_nxt.res_cnt = CW'(s_r.res_cnt + 1'b1);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_r <= '0;
            s_r.mode <= `FCS_MODE_RESET;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    assign FLASH_START = s_r.start;
    assign FLASH_OPCODE = s_r.op;
    assign FLASH_ARG = s_r.arg;
    assign FLASH_PAGE = s_r.page;
    assign FLASH_PAGE_COUNT = s_r.count;
    assign ID_AREA_SEL = s_r.id_sel;
    assign SIG_AREA_SEL = s_r.sig_sel;
    assign FLASH_WAIT_STATES = s_r.mode[`FCS_MODE_WS_HI:`FCS_MODE_WS_LO];
    assign SEQ_OPT_DISABLE = s_r.mode[`FCS_MODE_SEQ_DIS];
    assign ACCESS_64BIT = s_r.mode[`FCS_MODE_ACC64];
    assign LOOP_OPT_EN = s_r.mode[`FCS_MODE_LOOP_EN];
    assign READY_IRQ = ready & s_r.mode[`FCS_MODE_IRQ_EN];

    default clocking fcs_cb @(posedge CLOCK iff CE);
    endclocking
    default disable iff (RST);

    sequence good_cmd_s;
        cmd_wr && key_ok && dec.valid && ready;
    endsequence

    sequence started_s;
        FLASH_START && !ready;
    endsequence

    bad_key_a: assert property (cmd_wr && !key_ok && ready |=> ready && s_r.cmd_err
        && !FLASH_START) else $error("bad key started an operation");
    start_busy_a: assert property (good_cmd_s |=> started_s ##1 !FLASH_START)
        else $error("accepted command did not start once");
    done_ready_a: assert property (!ready && FLASH_DONE |=> ready && READY_IRQ ==
        s_r.mode[`FCS_MODE_IRQ_EN]) else $error("ready not restored");
    irq_ready_a: assert property (READY_IRQ |-> stat_word[`FCS_ST_READY])
        else $error("interrupt without ready");
    bad_op_a: assert property (cmd_wr && key_ok && !dec.valid |=> s_r.cmd_err && ready)
        else $error("undefined opcode not flagged");
    lock_flag_a: assert property (!ready && FLASH_DONE && s_r.prog && FLASH_LOCK_HIT
        |=> s_r.lock_err) else $error("lock hit not flagged");
    verify_clr_a: assert property (accept && dec.prog |=> !s_r.ver_err)
        else $error("verify error not cleared at start");
    ecc_single_a: assert property (ECC_SINGLE_LO || ECC_SINGLE_HI |=>
        s_r.ecc[0] || s_r.ecc[2]) else $error("single ecc event lost");
    ecc_hold_a: assert property (s_r.ecc[1] && !stat_rd |=> s_r.ecc[1])
        else $error("multi ecc flag dropped without read");
    epa_size_a: assert property (accept && rif.wdata[7:0] == `FCS_OP_ERASE_PAGES
        |-> dec.count == 6'(6'h04 << rif.wdata[9:8]))
        else $error("erase pages size wrong");
    epa_count_a: assert property (FLASH_START && FLASH_OPCODE == `FCS_OP_ERASE_PAGES
        |-> FLASH_PAGE_COUNT == 6'(6'h04 << FLASH_ARG[1:0]))
        else $error("erase pages count wrong");
endmodule // fcs_top
`default_nettype wire

// ==== fcs_flash_model.sv ====
// flash back end stand-in: each start keeps it busy DELAY cycles, then done
// assumes start and opcode from the front end on the same clock
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
    parameter int DELAY = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic vfail,
    input wire logic lhit,
    output logic done,
    output logic verify_fail,
    output logic lock_hit,
    output logic push,
    output logic [31:0] word
);
    int cnt = 0;
    logic [7:0] op_r = 8'h00;
    logic tog = 1'b0;
    assign done = (cnt == 1);
    // outcome lines mean nothing outside done, so keep them moving
    assign verify_fail = done ? vfail : tog;
    assign lock_hit = done ? lhit : ~tog;
    // query opcodes return two result words while busy
    assign push = (op_r inside {8'h00, 8'h0A, 8'h0D, 8'h10}) && (cnt == 4 || cnt == 3);
    assign word = push ? {op_r, 24'h00_0000} + 32'(cnt) : {32{tog}};
    always @(posedge clk) begin
        tog <= ~tog;
        if (rst) begin
            cnt <= 0;
        end else if (start) begin
            cnt <= DELAY;
            op_r <= opcode;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // fcs_flash_model
`default_nettype wire

// ==== flash_command_status_tb.sv ====
// self-checking bench for the flash command front end over AHB-Lite
// assumes fcs_top with the back end model; CE held high
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
module flash_command_status_tb;
    import fcs_pkg::*;
    logic CLOCK, RST = 1, HSEL = 0, HWRITE = 0, vfail = 0, lhit = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, rd;
    logic [1:0] HTRANS = 0;
    logic [3:0] ecc = 0;
    logic [31:0] HRDATA, RESULT_WORD;
    logic HREADYOUT, HRESP, FLASH_START, FLASH_DONE, FLASH_VERIFY_FAIL, FLASH_LOCK_HIT;
    logic RESULT_PUSH, ID_AREA_SEL, SIG_AREA_SEL, READY_IRQ, SEQ_OPT_DISABLE;
    logic ACCESS_64BIT, LOOP_OPT_EN;
    logic [7:0] FLASH_OPCODE;
    logic [15:0] FLASH_ARG, FLASH_PAGE;
    logic [5:0] FLASH_PAGE_COUNT;
    logic [3:0] FLASH_WAIT_STATES;
    int err_count = 0, tests_run = 0, starts = 0, dones = 0;

    fcs_top i_dut (.CLOCK(CLOCK), .RST(RST), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .FLASH_START(FLASH_START), .FLASH_OPCODE(FLASH_OPCODE), .FLASH_ARG(FLASH_ARG),
        .FLASH_PAGE(FLASH_PAGE), .FLASH_PAGE_COUNT(FLASH_PAGE_COUNT),
        .FLASH_DONE(FLASH_DONE), .FLASH_VERIFY_FAIL(FLASH_VERIFY_FAIL),
        .FLASH_LOCK_HIT(FLASH_LOCK_HIT), .RESULT_PUSH(RESULT_PUSH),
        .RESULT_WORD(RESULT_WORD), .ECC_SINGLE_LO(ecc[0]), .ECC_MULTI_LO(ecc[1]),
        .ECC_SINGLE_HI(ecc[2]), .ECC_MULTI_HI(ecc[3]), .ID_AREA_SEL(ID_AREA_SEL),
        .SIG_AREA_SEL(SIG_AREA_SEL), .FLASH_WAIT_STATES(FLASH_WAIT_STATES),
        .SEQ_OPT_DISABLE(SEQ_OPT_DISABLE), .ACCESS_64BIT(ACCESS_64BIT),
        .LOOP_OPT_EN(LOOP_OPT_EN), .READY_IRQ(READY_IRQ));

    fcs_flash_model i_model (.clk(CLOCK), .rst(RST), .start(FLASH_START),
        .opcode(FLASH_OPCODE), .vfail(vfail), .lhit(lhit), .done(FLASH_DONE),
        .verify_fail(FLASH_VERIFY_FAIL), .lock_hit(FLASH_LOCK_HIT),
        .push(RESULT_PUSH), .word(RESULT_WORD));

    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK) begin
        if (FLASH_START === 1'b1) starts <= starts + 1;
        if (FLASH_DONE === 1'b1) dones <= dones + 1;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        HSEL <= 1'b1;
        HADDR <= {24'h00_0000, a};
        HTRANS <= 2'b10;
        HWRITE <= w;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'b1) @(posedge CLOCK);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'b1) @(posedge CLOCK);
        rd = HRDATA;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task cmd(input logic [7:0] key, input logic [15:0] arg, input logic [7:0] op);
        bus(1'b1, `FCS_OFF_CMD, {key, arg, op});
    endtask

    task waitdone(input int n);
        for (int i = 0; i < 40 && dones == n; i++) @(posedge CLOCK);
        @(posedge CLOCK);
    endtask

    task run(input logic [7:0] op, input logic [15:0] arg);
        int n;
        n = dones;
        cmd(8'h5A, arg, op);
        bus(1'b0, `FCS_OFF_STATUS, 32'h0000_0000);
        chk(rd[0], 1'b0);
        waitdone(n);
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #100_000;
        err_count++;
        summarize();
    end

    initial begin
        int s, n;
        logic [15:0] arg;
        logic id, sg;
        id = 1'b0;
        sg = 1'b0;
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        rdchk(`FCS_OFF_STATUS, 32'h0000_0001);
        rdchk(`FCS_OFF_MODE, `FCS_MODE_RESET);
        rdchk(`FCS_OFF_RESULT, 32'h0000_0000);
        chk(READY_IRQ, 1'b0);
        chk(HRESP, 1'b0);
        rdchk(8'h10, 32'h0000_0000);
        rdchk(`FCS_OFF_CMD, 32'h0000_0000);
        for (int op = 0; op <= 8'h15; op++) begin
            // page argument for opcodes 1 to 4, 6, 7, 8, 9 and 17, bit argument for 11 and 12
            arg = (op inside {1, 2, 3, 4, 6, 7, 8, 9, 11, 12, 17}) ? 16'h0012 : 16'h0000;
            s = starts;
            run(8'(op), arg);
            chk(starts - s, 1);
            chk(FLASH_OPCODE, op);
            chk(FLASH_ARG, arg);
            rdchk(`FCS_OFF_STATUS, 32'h0000_0001);
            if (op == 8'h0E || op == 8'h0F) id = (op == 8'h0E);
            if (op == 8'h14 || op == 8'h15) sg = (op == 8'h14);
            chk({ID_AREA_SEL, SIG_AREA_SEL}, {id, sg});
            if (op inside {0, 8'h0A, 8'h0D, 8'h10}) begin
                rdchk(`FCS_OFF_RESULT, (op << 24) + 4);
                rdchk(`FCS_OFF_RESULT, (op << 24) + 3);
                rdchk(`FCS_OFF_RESULT, 32'h0000_0000);
            end
        end
        for (int k = 0; k < 4; k++) begin
            // start page 64 is aligned for every group size
            run(`FCS_OP_ERASE_PAGES, 16'h0040 | 16'(k));
            chk(FLASH_PAGE_COUNT, 4 << k);
            chk(FLASH_PAGE, 16'h0040);
        end
        s = starts;
        cmd(8'hA5, 16'h0000, `FCS_OP_WRITE_PAGE);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0003);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0001);
        cmd(8'h5A, 16'h0000, 8'h16);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0003);
        chk(starts - s, 0);
        n = dones;
        cmd(8'h5A, 16'h0005, `FCS_OP_WRITE_PAGE);
        cmd(8'h5A, 16'h0006, `FCS_OP_WRITE_LOCK);
        waitdone(n);
        chk(starts - s, 1);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0003);
        lhit <= 1'b1;
        run(`FCS_OP_ERASE_WRITE, 16'h0007);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0005);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0001);
        run(`FCS_OP_ERASE_WRITE, 16'h0007);
        lhit <= 1'b0;
        cmd(8'h00, 16'h0000, `FCS_OP_WRITE_PAGE);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0003);
        vfail <= 1'b1;
        run(`FCS_OP_WRITE_PAGE, 16'h0007);
        vfail <= 1'b0;
        rdchk(`FCS_OFF_STATUS, 32'h0000_0009);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0009);
        run(`FCS_OP_WRITE_PAGE, 16'h0007);
        rdchk(`FCS_OFF_STATUS, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            ecc <= 4'(1 << i);
            @(posedge CLOCK);
            ecc <= 4'h0;
            rdchk(`FCS_OFF_STATUS, 32'h0000_0001 | (32'h0000_0001 << (16 + i)));
            rdchk(`FCS_OFF_STATUS, 32'h0000_0001);
        end
        bus(1'b1, `FCS_OFF_MODE, 32'hFFFF_FFFF);
        rdchk(`FCS_OFF_MODE, `FCS_MODE_MASK);
        chk({LOOP_OPT_EN, ACCESS_64BIT, SEQ_OPT_DISABLE, FLASH_WAIT_STATES}, 7'h7F);
        chk(READY_IRQ, 1'b1);
        n = dones;
        cmd(8'h5A, 16'h0000, `FCS_OP_GET_LOCK);
        @(posedge CLOCK);
        chk(READY_IRQ, 1'b0);
        waitdone(n);
        chk(READY_IRQ, 1'b1);
        summarize();
    end
endmodule // flash_command_status_tb
`default_nettype wire
